// File: pcie_pkg.sv
// Function
// R1: with page override set, page field supplies register address bits 5 and 4.
// R2: with page override clear, the address latch alone forms the full address.
// R3: page field is only used while page override is enabled.
// R4: writing one to receiver-disable bit switches the receiver analog section off.
// R5: writing one to the soft sleep bit enters soft power-down.
// R6: clearing soft sleep starts wake-up; bit reads one until wake-up completes.
// R7: soft sleep cannot be set while the software reset command is active.
// R8: writing the command field starts the matching command.
// R9: command field reads the executing command; sequencer may change it.
// R10: invert bit one drives the interrupt pin as inverse of combined status.
// R11: invert bit zero drives the interrupt pin equal to combined status.
// R12: invert resets to one so the open-drain pin rests high impedance.
// R13: transmit-done enable gates the transmit-complete request.
// R14: receive-done enable gates the receiver request.
// R15: idle enable gates the idle request.
// R16: high-alert enable gates the buffer high-level request.
// R17: low-alert enable gates the buffer low-level request.
// R18: error enable gates the error request.
// R19: timer enable gates the timer-expired request.
// R20: command register resets to 20h.
// R21: reserved bits read as zero; host writes zero.
// R22: drive type bit one gives push-pull, zero gives open-drain.
// R23: combined status is OR of each flag ANDed with its enable.
package pcie_pkg;
  localparam logic [5:0] PCIE_ADDR_PAGE = 6'h00;
  localparam logic [5:0] PCIE_ADDR_CMD = 6'h01;
  localparam logic [5:0] PCIE_ADDR_IEN = 6'h02;
  localparam logic [7:0] PCIE_PAGE_RST = 8'h00;
  localparam logic [7:0] PCIE_CMD_RST = 8'h20;
  localparam logic [7:0] PCIE_IEN_RST = 8'h80;
  localparam logic [7:0] PCIE_PAGE_MASK = 8'h83;
  localparam logic [7:0] PCIE_CMD_MASK = 8'h3F;
  localparam int PCIE_PAGE_OVR_BIT = 7;
  localparam int PCIE_RCV_OFF_BIT = 5;
  localparam int PCIE_SLEEP_BIT = 4;
  localparam int PCIE_INV_BIT = 7;
  localparam logic [3:0] PCIE_CMD_SOFT_RESET = 4'hF;
  localparam int PCIE_WAKE_NS = 1000;
  localparam int PCIE_CLK_NS = 50;
  localparam logic [7:0] PCIE_WAKE_CYC = 8'((PCIE_WAKE_NS + PCIE_CLK_NS - 1) / PCIE_CLK_NS);
  typedef enum logic [2:0]
  {
    PCIE_AWAKE = 3'b001,
    PCIE_ASLEEP = 3'b010,
    PCIE_WAKING = 3'b100
  } pcie_pwr_t;
  function automatic logic [7:0] pcie_wmask(input logic [7:0] d, input logic [7:0] m);
    pcie_wmask = d & m;
  endfunction
endpackage

// File: pcie_addr_map.sv
module pcie_addr_map
  import pcie_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] latch_addr,
  input wire logic page_override_en,
  input wire logic [1:0] page_field,
  output logic [5:0] eff_addr
);
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      eff_addr <= 6'h00;
    end
    else if (page_override_en)
    begin
      eff_addr <= {page_field, latch_addr[3:0]}; // R1 R3
    end
    else
    begin
      eff_addr <= latch_addr; // R2
    end
  end
endmodule

// File: pcie_irq_pin.sv
module pcie_irq_pin
  import pcie_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [6:0] flags,
  input wire logic [6:0] enables,
  input wire logic [4:0] flags2,
  input wire logic [4:0] enables2,
  input wire logic invert,
  input wire logic push_pull,
  output logic irq_status,
  output logic irq_o,
  output logic irq_oe
);
  logic comb;
  logic level;
  assign comb = |(flags & enables) | |(flags2 & enables2); // R13 R14 R15 R16 R17 R18 R19 R23
  assign level = comb ^ invert; // R10 R11
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      irq_status <= 1'b0;
      irq_o <= 1'b0;
      irq_oe <= 1'b0;
    end
    else
    begin
      irq_status <= comb;
      irq_o <= level;
      irq_oe <= push_pull | ~level; // R22 R12
    end
  end
endmodule

// File: pcie_regs.sv
module pcie_regs
  import pcie_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [5:0] latch_addr,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] wr_data,
  output logic [7:0] rd_data,
  output logic [5:0] eff_addr,
  output logic page_override_en,
  output logic [1:0] page_field,
  output logic receiver_analog_disable,
  output logic soft_sleep,
  output logic [3:0] cmd_code,
  output logic cmd_start,
  input wire logic seq_cmd_load,
  input wire logic [3:0] seq_cmd_code,
  input wire logic [6:0] irq_flags,
  input wire logic [4:0] irq_flags2,
  input wire logic [4:0] irq_en2,
  input wire logic interrupt_pin_drive_type,
  output logic irq_status,
  output logic irq_o,
  output logic irq_oe
);
  logic [7:0] page_reg;
  logic [7:0] cmd_reg;
  logic [7:0] ien_reg;
  logic [7:0] cmd_next;
  logic [7:0] wake_cnt_reg;
  pcie_pwr_t pwr_reg;
  logic wr_page;
  logic wr_cmd;
  logic wr_ien;
  logic soft_reset_active;

  pcie_addr_map u_map
  (
    .clk(clk),
    .rst_n(rst_n),
    .latch_addr(latch_addr),
    .page_override_en(page_reg[PCIE_PAGE_OVR_BIT]),
    .page_field(page_reg[1:0]),
    .eff_addr(eff_addr)
  );

  pcie_irq_pin u_irq
  (
    .clk(clk),
    .rst_n(rst_n),
    .flags(irq_flags),
    .enables(ien_reg[6:0]),
    .flags2(irq_flags2),
    .enables2(irq_en2),
    .invert(ien_reg[PCIE_INV_BIT]),
    .push_pull(interrupt_pin_drive_type),
    .irq_status(irq_status),
    .irq_o(irq_o),
    .irq_oe(irq_oe)
  );

  // decode uses the combinational effective address of this access
  logic [5:0] dec_addr;
  assign dec_addr = page_reg[PCIE_PAGE_OVR_BIT] ? {page_reg[1:0], latch_addr[3:0]} : latch_addr;
  // the page register sits at offset 0 of every page, so paging can always be undone
  assign wr_page = wr_en && (dec_addr[3:0] == PCIE_ADDR_PAGE[3:0]);
  assign wr_cmd = wr_en && (dec_addr == PCIE_ADDR_CMD);
  assign wr_ien = wr_en && (dec_addr == PCIE_ADDR_IEN);
  assign soft_reset_active = (cmd_reg[3:0] == PCIE_CMD_SOFT_RESET);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      page_reg <= PCIE_PAGE_RST;
    end
    else if (wr_page)
    begin
      page_reg <= pcie_wmask(wr_data, PCIE_PAGE_MASK); // R21
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      ien_reg <= PCIE_IEN_RST; // R12
    end
    else if (wr_ien)
    begin
      ien_reg <= wr_data;
    end
  end

  always_comb
  begin
    cmd_next = cmd_reg;
    if (seq_cmd_load)
    begin
      cmd_next[3:0] = seq_cmd_code; // R9
    end
    if (wr_cmd)
    begin
      cmd_next[PCIE_RCV_OFF_BIT] = wr_data[PCIE_RCV_OFF_BIT]; // R4
      cmd_next[3:0] = wr_data[3:0]; // R8
    end
    // sleep bit shows one while asleep or still waking
    cmd_next[PCIE_SLEEP_BIT] = (pwr_reg != PCIE_AWAKE); // R6
    cmd_next = pcie_wmask(cmd_next, PCIE_CMD_MASK); // R21
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cmd_reg <= PCIE_CMD_RST; // R20
      cmd_start <= 1'b0;
    end
    else
    begin
      cmd_reg <= cmd_next;
      cmd_start <= wr_cmd;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pwr_reg <= PCIE_AWAKE;
      wake_cnt_reg <= 8'h00;
    end
    else
    begin
      unique case (pwr_reg)
        PCIE_AWAKE:
        begin
          if (wr_cmd && wr_data[PCIE_SLEEP_BIT] && !soft_reset_active) // R5 R7
          begin
            pwr_reg <= PCIE_ASLEEP;
          end
        end
        PCIE_ASLEEP:
        begin
          if (wr_cmd && !wr_data[PCIE_SLEEP_BIT])
          begin
            pwr_reg <= PCIE_WAKING; // R6
            wake_cnt_reg <= PCIE_WAKE_CYC;
          end
        end
        PCIE_WAKING:
        begin
          if (wake_cnt_reg <= 8'h01)
          begin
            pwr_reg <= PCIE_AWAKE;
            wake_cnt_reg <= 8'h00;
          end
          else
          begin
            wake_cnt_reg <= wake_cnt_reg - 8'h01;
          end
        end
        default:
        begin
          pwr_reg <= PCIE_AWAKE;
        end
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      rd_data <= 8'h00;
    end
    else if (rd_en && (dec_addr[3:0] == PCIE_ADDR_PAGE[3:0]))
    begin
      rd_data <= page_reg;
    end
    else if (rd_en)
    begin
      unique case (dec_addr)
        PCIE_ADDR_PAGE: rd_data <= page_reg;
        PCIE_ADDR_CMD: rd_data <= cmd_reg;
        PCIE_ADDR_IEN: rd_data <= ien_reg;
        default: rd_data <= 8'h00;
      endcase
    end
  end

  assign page_override_en = page_reg[PCIE_PAGE_OVR_BIT];
  assign page_field = page_reg[1:0];
  assign receiver_analog_disable = cmd_reg[PCIE_RCV_OFF_BIT];
  assign soft_sleep = cmd_reg[PCIE_SLEEP_BIT];
  assign cmd_code = cmd_reg[3:0];

  reset_default_a: assert property (@(posedge clk) $rose(rst_n) |-> cmd_reg == PCIE_CMD_RST)
    else $error("command register reset value wrong"); // R20
  sleep_block_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pwr_reg == PCIE_AWAKE && soft_reset_active) |=> pwr_reg == PCIE_AWAKE)
    else $error("sleep entered during soft reset"); // R7
  wake_shows_one_a: assert property (@(posedge clk) disable iff (!rst_n)
    (pwr_reg == PCIE_WAKING) |=> cmd_reg[PCIE_SLEEP_BIT])
    else $error("sleep bit dropped early"); // R6
  wake_bounded_a: assert property (@(posedge clk) disable iff (!rst_n)
    $rose(pwr_reg == PCIE_WAKING) |-> ##[1:40] pwr_reg == PCIE_AWAKE)
    else $error("wake-up did not complete"); // R6
  rcv_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cmd |=> receiver_analog_disable == $past(wr_data[PCIE_RCV_OFF_BIT]))
    else $error("receiver disable not written"); // R4
  cmd_write_a: assert property (@(posedge clk) disable iff (!rst_n)
    wr_cmd |=> cmd_code == $past(wr_data[3:0]) && cmd_start)
    else $error("command not started"); // R8
  reserved_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
    page_reg[6:2] == 5'h00 && cmd_reg[7:6] == 2'h0)
    else $error("reserved bits nonzero"); // R21
  irq_level_a: assert property (@(posedge clk) disable iff (!rst_n)
    $stable(irq_flags) && $stable(ien_reg) && $stable(irq_flags2) && $stable(irq_en2)
    |=> irq_o == (irq_status ^ $past(ien_reg[PCIE_INV_BIT])))
    else $error("interrupt pin level wrong"); // R10 R11
endmodule

// File: pcie_host.sv
module pcie_host (
  input wire logic clk,
  input wire logic [7:0] rd_data,
  output logic [5:0] latch_addr,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] wr_data
);
  timeunit 1ns;
  timeprecision 1ns;
  initial
  begin
    latch_addr = 6'h00;
    wr_en = 1'b0;
    rd_en = 1'b0;
    wr_data = 8'h00;
  end
  // one access held for one edge; released address and data lines show the inverse value, both strobes drop to zero
  task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    @(posedge clk);
    wr_en <= w;
    rd_en <= ~w;
    latch_addr <= a;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    latch_addr <= ~a;
    wr_data <= ~d;
    #1 q = rd_data;
  endtask
endmodule

// File: testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk, rst_n, wr_en, rd_en, seq_cmd_load, pp, irq_o, irq_oe, rad, sleep;
  logic [5:0] latch_addr;
  logic [7:0] wr_data, rd_data, q;
  logic [3:0] seq_cmd_code, cmd_code;
  logic [6:0] flags;
  logic [4:0] flags2, en2;
  logic [5:0] eff;
  logic [1:0] pf;
  logic po, cs, ist;
  int n_fail = 0;
  int compares = 0;
  int n;
  pcie_host h (.clk(clk), .rd_data(rd_data), .latch_addr(latch_addr), .wr_en(wr_en),
    .rd_en(rd_en), .wr_data(wr_data));
  pcie_regs dut (.clk(clk), .rst_n(rst_n), .latch_addr(latch_addr), .wr_en(wr_en),
    .rd_en(rd_en), .wr_data(wr_data), .rd_data(rd_data), .eff_addr(eff),
    .page_override_en(po), .page_field(pf), .receiver_analog_disable(rad),
    .soft_sleep(sleep), .cmd_code(cmd_code), .cmd_start(cs), .seq_cmd_load(seq_cmd_load),
    .seq_cmd_code(seq_cmd_code), .irq_flags(flags), .irq_flags2(flags2),
    .irq_en2(en2), .interrupt_pin_drive_type(pp), .irq_status(ist), .irq_o(irq_o),
    .irq_oe(irq_oe));
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    h.acc(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    h.acc(1'b0, a, 8'h00, q);
    chk(q, exp);
  endtask
  task automatic pin_chk(input logic [7:0] exp);
    repeat (2) @(posedge clk);
    #1 chk({6'h00, irq_oe, irq_o}, exp);
  endtask
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial
  begin
    rst_n = 1'b0;
    seq_cmd_load = 1'b0;
    seq_cmd_code = 4'h0;
    pp = 1'b0;
    flags = 7'h00;
    flags2 = 5'h00;
    en2 = 5'h00;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    rd_chk(6'h00, 8'h00);
    rd_chk(6'h01, 8'h20);
    rd_chk(6'h02, 8'h80);
    pin_chk(8'h01);
    $display("test reset done");
    wr(6'h00, 8'h03);
    rd_chk(6'h02, 8'h80);
    rd_chk(6'h00, 8'h03);
    wr(6'h00, 8'h80);
    rd_chk(6'h32, 8'h80);
    chk({2'h0, eff}, 8'h02);
    wr(6'h00, 8'h81);
    chk({po, 5'h00, pf}, 8'h81);
    rd_chk(6'h02, 8'h00);
    wr(6'h00, 8'h00);
    rd_chk(6'h02, 8'h80);
    $display("test paging done");
    wr(6'h01, 8'hE5);
    chk({3'h0, rad, cmd_code}, 8'h15);
    chk({7'h00, cs}, 8'h01);
    rd_chk(6'h01, 8'h25);
    @(posedge clk);
    seq_cmd_load <= 1'b1;
    @(posedge clk);
    seq_cmd_load <= 1'b0;
    rd_chk(6'h01, 8'h20);
    wr(6'h01, 8'h10);
    @(posedge clk);
    #1 chk({7'h00, sleep}, 8'h01);
    wr(6'h01, 8'h00);
    rd_chk(6'h01, 8'h10);
    for (n = 0; n < 40 && sleep !== 1'b0; n++)
      @(posedge clk);
    if (sleep !== 1'b0)
    begin
      n_fail++;
      tally_and_finish();
    end
    rd_chk(6'h01, 8'h00);
    wr(6'h01, 8'h0F);
    wr(6'h01, 8'h1F);
    rd_chk(6'h01, 8'h0F);
    $display("test command done");
    for (int i = 0; i < 7; i++)
    begin
      flags <= 7'(1 << i);
      wr(6'h02, 8'(1 << i));
      pin_chk(8'h01);
      wr(6'h02, 8'h80 | 8'(1 << i));
      pin_chk(8'h02);
      wr(6'h02, 8'h7F & ~8'(1 << i));
      pin_chk(8'h02);
    end
    flags <= 7'h00;
    flags2 <= 5'h01;
    en2 <= 5'h01;
    pp <= 1'b1;
    wr(6'h02, 8'h00);
    pin_chk(8'h03);
    chk({7'h00, ist}, 8'h01);
    $display("test interrupt done");
    tally_and_finish();
  end
endmodule
